// ===== sram_ctrl_consts.vh
// Shared constants of the synchronous burst SRAM control block
`ifndef SRAM_CTRL_CONSTS_VH
`define SRAM_CTRL_CONSTS_VH

// ==============================================
// Array geometry
`define ADDR_W 16
`define DATA_W 16
`define WORD_W 18
`define MEM_WORDS 65536
`define LOW_W 2
`define LOW_ONE 2'h1

// ==============================================
// Stored word layout: parity bits above the data
`define LO_MSB 7
`define HI_LSB 8
`define HI_MSB 15
`define LO_PAR_BIT 16
`define HI_PAR_BIT 17

// ==============================================
// APB register byte offsets
`define APB_ADDR_W 8
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_TRACE 8'h08

// ==============================================
// Control and status fields
`define CTRL_TRACE_EN 0
`define CTRL_ORDER_OVR 1
`define CTRL_ORDER_VAL 2
`define ST_ADDR_MSB 15
`define ST_SELECTED 16
`define ST_DRIVING 17
`define ST_OVERFLOW 18
`define ST_TRACE_VALID 19
`define CTRL_RESET 32'h0000_0001

// ==============================================
// Trace word: cycle kind above the address
`define TRACE_W 18
`define TRACE_DEPTH 4
`define TRACE_PTR_W 2
`define OP_READ 2'h1
`define OP_WRITE 2'h2

`endif

// ===== sram_master_model.sv
// Bus master model standing in for the processor or cache controller
`timescale 1ns/1ps
`default_nettype none
// ==========================
// Master model
module sram_master_model (
  input wire clock,
  output reg [15:0] ext_addr,
  output reg chip_select_n,
  output reg second_select_n,
  output reg third_select,
  output reg proc_addr_strobe_n,
  output reg ctrl_addr_strobe_n,
  output reg burst_advance_n,
  output reg global_wr_n,
  output reg byte_wr_gate_n,
  output reg upper_byte_wr_n,
  output reg lower_byte_wr_n,
  output reg output_enable_n,
  output wire [17:0] bus,
  input wire [15:0] data_io_bus_out,
  input wire lower_parity_bit_out,
  input wire upper_parity_bit_out,
  input wire data_io_bus_oe_n,
  input wire lower_parity_bit_oe_n,
  input wire upper_parity_bit_oe_n
);
  reg drv; // Master drives write data
  reg [17:0] wd; // Write data
  reg [17:0] last; // Last level, inverted when nobody drives
  wire [17:0] oe = {upper_parity_bit_oe_n, lower_parity_bit_oe_n, {16{data_io_bus_oe_n}}};
  wire [17:0] dev = {upper_parity_bit_out, lower_parity_bit_out, data_io_bus_out};
  // Wire level from both parties' enables
  assign bus = (~oe & dev) | (oe & (drv ? wd : ~last));
  always @(posedge clock) last <= bus;
  // Idle: selected, strobes high, no write
  initial begin
    {ext_addr, chip_select_n, second_select_n, drv, wd, last} = 0;
    {third_select, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = 4'hF;
    {global_wr_n, byte_wr_gate_n, upper_byte_wr_n, lower_byte_wr_n, output_enable_n} = 5'h1F;
  end
  // One cycle; q is the previous cycle's result with its drive flag
  task op(input [2:0] k, input [15:0] a, input [3:0] wc, input [17:0] d, output [18:0] q);
    reg ws;
    begin
      ws = !wc[3] || (!wc[2] && wc[1:0] != 2'b11);
      @(posedge clock);
      ext_addr <= a;
      chip_select_n <= k == 4 || k == 5;
      second_select_n <= k == 7;
      third_select <= k != 6;
      proc_addr_strobe_n <= !(k == 2 || k == 4 || k == 6);
      ctrl_addr_strobe_n <= !(k == 3 || k == 5 || k == 7);
      burst_advance_n <= !(k == 1 || k == 4);
      {global_wr_n, byte_wr_gate_n, upper_byte_wr_n, lower_byte_wr_n} <= wc;
      output_enable_n <= ws;
      drv <= ws;
      wd <= d;
      @(negedge clock);
      q = {data_io_bus_oe_n, dev};
    end
  endtask
endmodule
`default_nettype wire

// ===== sync_burst_sram_ctrl.v
// Synchronous burst SRAM core: cycle decode, burst counter, array, APB
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "sram_ctrl_consts.vh"

// How it works
// - Order pin low: linear low-bit count, wrapping
// - Order pin high: start XOR 01, 10, 11
// - Primary low, secondary off, any strobe; or controller strobe, primary off: deselect, float data
// - Processor strobe, all selects: external read
// - Controller strobe only: begin write or read
// - Strobes high, advance low: step and access
// - Primary select high ignores processor strobe
// - Advance high: hold address, same access again
// - Write when global, or gate plus byte
// - Each byte enable writes its byte and parity
// - Global wins; high gate means read
// - Data pins float from power-up
// - Output enable gates read drive, asynchronously
module sync_burst_sram_ctrl (
  input wire clock,
  input wire rst,
  // SRAM side, all sampled on the rising edge except output_enable_n
  input wire [`ADDR_W-1:0] ext_addr,
  input wire chip_select_n,
  input wire second_select_n,
  input wire third_select,
  input wire proc_addr_strobe_n,
  input wire ctrl_addr_strobe_n,
  input wire burst_advance_n,
  input wire global_wr_n,
  input wire byte_wr_gate_n,
  input wire upper_byte_wr_n,
  input wire lower_byte_wr_n,
  input wire output_enable_n,
  input wire burst_order_mode,
  input wire [`DATA_W-1:0] data_io_bus_in,
  output reg [`DATA_W-1:0] data_io_bus_out,
  output wire data_io_bus_oe_n,
  input wire lower_parity_bit_in,
  output reg lower_parity_bit_out,
  output wire lower_parity_bit_oe_n,
  input wire upper_parity_bit_in,
  output reg upper_parity_bit_out,
  output wire upper_parity_bit_oe_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`APB_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr
);

  // ==============================================
  // Cycle kinds, one-hot
  localparam [5:0] CYC_NONE = 6'b000001; // Deselected and idle
  localparam [5:0] CYC_DESEL = 6'b000010; // Explicit deselect
  localparam [5:0] CYC_PROC = 6'b000100; // Processor-strobe begin
  localparam [5:0] CYC_CTRL = 6'b001000; // Controller-strobe begin
  localparam [5:0] CYC_NEXT = 6'b010000; // Continue burst
  localparam [5:0] CYC_HOLD = 6'b100000; // Suspend burst

  // Device states, one-hot
  localparam [1:0] ST_IDLE = 2'b01; // Deselected, no burst open
  localparam [1:0] ST_BURST = 2'b10; // A burst is open

  // ==============================================
  // State
  reg [1:0] state; // Selected or not
  reg [`ADDR_W-1:0] cur_addr; // Address of the last access
  reg [`LOW_W-1:0] start_low; // Low bits of the external start
  reg [`LOW_W-1:0] burst_cnt; // Steps taken in this burst
  reg drive; // Last cycle was a read that may drive
  reg [`WORD_W-1:0] mem [0:`MEM_WORDS-1]; // The array
  reg [31:0] ctrl; // Trace enable and order override
  reg overflow; // Trace event lost while FIFO full

  // Combinational decode results
  reg [5:0] cyc; // Kind of this edge's cycle
  reg [1:0] next_state;
  reg [`ADDR_W-1:0] next_addr; // Address used this edge
  reg [`LOW_W-1:0] next_cnt;
  reg do_write; // Array written this edge
  reg do_read; // Array read this edge
  wire write_req; // Combined write strobe, high = write
  wire wr_lower; // Lower byte lane enabled
  wire wr_upper; // Upper byte lane enabled
  wire sec_ok; // Both secondary selects active
  wire order_interleaved; // Effective burst order
  wire [`WORD_W-1:0] old_word;
  wire [`WORD_W-1:0] in_word;

  // Trace path
  wire trace_in_ready;
  wire trace_out_valid;
  wire [`TRACE_W-1:0] trace_out;
  wire trace_push;
  wire trace_pop;
  wire apb_access; // Access phase edge at which the slave answers
  wire [`TRACE_W-1:0] trace_word;

  // ==============================================
  // Helper functions
  // Low address bits for step n of a burst from start s
  function [`LOW_W-1:0] burst_low;
    input [`LOW_W-1:0] s;
    input [`LOW_W-1:0] n;
    input interleaved;
    begin
      if (interleaved) begin
        burst_low = s ^ n;
      end else begin
        burst_low = s + n;
      end
    end
  endfunction

  // Merge incoming lanes into the stored word, lane by lane
  function [`WORD_W-1:0] merge_word;
    input [`WORD_W-1:0] old_w;
    input [`WORD_W-1:0] new_w;
    input lo;
    input hi;
    reg [`WORD_W-1:0] m;
    begin
      m = old_w;
      if (lo) begin
        m[`LO_MSB:0] = new_w[`LO_MSB:0];
        m[`LO_PAR_BIT] = new_w[`LO_PAR_BIT];
      end
      if (hi) begin
        m[`HI_MSB:`HI_LSB] = new_w[`HI_MSB:`HI_LSB];
        m[`HI_PAR_BIT] = new_w[`HI_PAR_BIT];
      end
      merge_word = m;
    end
  endfunction

  // ==============================================
  // Write strobe decode
  // Global write overrides everything; a high gate makes byte enables moot
  assign wr_lower = !global_wr_n || (!byte_wr_gate_n && !lower_byte_wr_n);
  assign wr_upper = !global_wr_n || (!byte_wr_gate_n && !upper_byte_wr_n);
  assign write_req = wr_lower || wr_upper;
  assign sec_ok = !second_select_n && third_select;
  // Software may override the order pin, otherwise the pin rules
  assign order_interleaved = ctrl[`CTRL_ORDER_OVR] ? ctrl[`CTRL_ORDER_VAL]
                                                   : burst_order_mode;
  assign in_word = {upper_parity_bit_in, lower_parity_bit_in, data_io_bus_in};
  assign old_word = mem[next_addr];

  // ==============================================
  // Cycle decode, in priority order
  always @* begin
    cyc = CYC_NONE;
    next_state = state;
    next_addr = cur_addr;
    next_cnt = burst_cnt;
    do_write = 1'b0;
    do_read = 1'b0;
    if (!chip_select_n && !sec_ok && (!proc_addr_strobe_n || !ctrl_addr_strobe_n)) begin
      // A strobe with a secondary select off closes the device
      cyc = CYC_DESEL;
      next_state = ST_IDLE;
    end else if (chip_select_n && !ctrl_addr_strobe_n) begin
      // Controller strobe with primary select off also deselects
      cyc = CYC_DESEL;
      next_state = ST_IDLE;
    end else if (!proc_addr_strobe_n && !chip_select_n) begin
      // Processor strobe is honoured only with the primary select low
      cyc = CYC_PROC;
      next_state = ST_BURST;
      next_addr = ext_addr;
      next_cnt = {`LOW_W{1'b0}};
      do_read = 1'b1;
    end else if (!ctrl_addr_strobe_n) begin
      cyc = CYC_CTRL;
      next_state = ST_BURST;
      next_addr = ext_addr;
      next_cnt = {`LOW_W{1'b0}};
      do_write = write_req;
      do_read = !write_req;
    end else if (state == ST_BURST) begin
      // No strobe honoured: selects no longer matter
      if (!burst_advance_n) begin
        cyc = CYC_NEXT;
        next_cnt = burst_cnt + `LOW_ONE;
        // Upper bits frozen, so a burst never leaves its four words
        next_addr = {cur_addr[`ADDR_W-1:`LOW_W],
                     burst_low(start_low, next_cnt, order_interleaved)};
      end else begin
        // Wait cycle on the same word; lets the master turn a read into a write
        cyc = CYC_HOLD;
      end
      do_write = write_req;
      do_read = !write_req;
    end
  end

  // ==============================================
  // Burst state, address and read data register
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      cur_addr <= {`ADDR_W{1'b0}};
      start_low <= {`LOW_W{1'b0}};
      burst_cnt <= {`LOW_W{1'b0}};
      drive <= 1'b0;
      data_io_bus_out <= {`DATA_W{1'b0}};
      lower_parity_bit_out <= 1'b0;
      upper_parity_bit_out <= 1'b0;
    end else begin
      case (next_state)
        ST_IDLE: begin
          state <= ST_IDLE;
        end
        ST_BURST: begin
          state <= ST_BURST;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      cur_addr <= next_addr;
      burst_cnt <= next_cnt;
      if (cyc == CYC_PROC || cyc == CYC_CTRL) begin
        start_low <= ext_addr[`LOW_W-1:0];
      end
      // Only read cycles may drive; writes and deselects float the pins
      drive <= do_read;
      if (do_read) begin
        data_io_bus_out <= old_word[`DATA_W-1:0];
        lower_parity_bit_out <= old_word[`LO_PAR_BIT];
        upper_parity_bit_out <= old_word[`HI_PAR_BIT];
      end
    end
  end

  // Output enable acts without the clock, so it gates the drive flag
  // directly; this trades a flop-only output for the documented behaviour
  assign data_io_bus_oe_n = output_enable_n || !drive;
  assign lower_parity_bit_oe_n = output_enable_n || !drive;
  assign upper_parity_bit_oe_n = output_enable_n || !drive;

  // ==============================================
  // Array write port, no reset on storage
  always @(posedge clock) begin
    if (do_write) begin
      mem[next_addr] <= merge_word(old_word, in_word, wr_lower, wr_upper);
    end
  end

  // ==============================================
  // Access trace: every array access is logged while enabled and the FIFO is not full
  assign trace_word = {(do_write ? `OP_WRITE : `OP_READ), next_addr};
  assign trace_push = ctrl[`CTRL_TRACE_EN] && (do_write || do_read);
  assign apb_access = psel && penable && !pready;
  assign trace_pop = apb_access && !pwrite && (paddr == `REG_TRACE);

  trace_fifo #(
    .WIDTH(`TRACE_W),
    .DEPTH(`TRACE_DEPTH),
    .PTR_W(`TRACE_PTR_W)
  ) u_trace (
    .clock(clock),
    .rst(rst),
    .in_valid(trace_push),
    .in_ready(trace_in_ready),
    .in_data(trace_word),
    .out_valid(trace_out_valid),
    .out_ready(trace_pop),
    .out_data(trace_out)
  );

  // ==============================================
  // APB slave: answers one cycle into the access phase
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      ctrl <= `CTRL_RESET;
      overflow <= 1'b0;
    end else begin
      pready <= apb_access;
      pslverr <= 1'b0;
      // A full FIFO stalls logging; the loss is made visible
      if (trace_push && !trace_in_ready) begin
        overflow <= 1'b1;
      end else if (apb_access && pwrite && paddr == `REG_STATUS
                   && pwdata[`ST_OVERFLOW]) begin
        // Write one to clear; a new loss in the same edge wins above
        overflow <= 1'b0;
      end
      if (apb_access) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          `REG_CTRL: begin
            if (pwrite) begin
              ctrl <= {29'h0000_0000, pwdata[`CTRL_ORDER_VAL:0]};
            end else begin
              prdata <= ctrl;
            end
          end
          `REG_STATUS: begin
            if (!pwrite) begin
              prdata[`ST_ADDR_MSB:0] <= cur_addr;
              prdata[`ST_SELECTED] <= (state == ST_BURST);
              prdata[`ST_DRIVING] <= drive;
              prdata[`ST_OVERFLOW] <= overflow;
              prdata[`ST_TRACE_VALID] <= trace_out_valid;
            end
          end
          `REG_TRACE: begin
            // Read pops; an empty FIFO reads zero with valid low
            if (!pwrite) begin
              prdata[`TRACE_W-1:0] <= trace_out_valid ? trace_out
                                                      : {`TRACE_W{1'b0}};
              prdata[31] <= trace_out_valid;
            end
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ===== sync_burst_sram_ctrl_properties.sv
// Port checker of the burst SRAM core, bound to its top module
`timescale 1ns/1ps
`default_nettype none
// ==========================
// Checker
module sram_ctrl_checker (
  input wire clock,
  input wire rst,
  input wire chip_select_n,
  input wire second_select_n,
  input wire third_select,
  input wire proc_addr_strobe_n,
  input wire ctrl_addr_strobe_n,
  input wire global_wr_n,
  input wire byte_wr_gate_n,
  input wire upper_byte_wr_n,
  input wire lower_byte_wr_n,
  input wire output_enable_n,
  input wire data_io_bus_oe_n,
  input wire lower_parity_bit_oe_n,
  input wire upper_parity_bit_oe_n,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr
);
  // Combined write strobe
  wire wr = !global_wr_n || (!byte_wr_gate_n && !(upper_byte_wr_n && lower_byte_wr_n));
  // Both secondary selects active
  wire sec_ok = !second_select_n && third_select;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  oe_gate_a: assert property (
    output_enable_n |-> data_io_bus_oe_n)
    else $error("data driven with output enable high");
  desel_prim_a: assert property (
    chip_select_n && !ctrl_addr_strobe_n |=> data_io_bus_oe_n)
    else $error("primary deselect left pins driven");
  desel_sec_a: assert property (
    !chip_select_n && !sec_ok && !(proc_addr_strobe_n && ctrl_addr_strobe_n)
    |=> data_io_bus_oe_n)
    else $error("secondary deselect left pins driven");
  proc_read_a: assert property (
    !proc_addr_strobe_n && !chip_select_n && sec_ok |=> output_enable_n || !data_io_bus_oe_n)
    else $error("processor strobe did not start a read");
  write_float_a: assert property (
    wr && (proc_addr_strobe_n || chip_select_n) |=> data_io_bus_oe_n)
    else $error("write cycle drove the pins");
  par_lanes_a: assert property (
    data_io_bus_oe_n == lower_parity_bit_oe_n && data_io_bus_oe_n == upper_parity_bit_oe_n)
    else $error("parity drive differs from data drive");
  apb_ready_a: assert property (
    psel && penable && !pready |=> pready)
    else $error("access not answered in one cycle");
  ready_pulse_a: assert property (
    pready |=> !pready)
    else $error("ready held longer than one cycle");
  err_ready_a: assert property (
    pslverr |-> pready)
    else $error("error without ready");
  // Main scenarios
  proc_read_c: cover property (!proc_addr_strobe_n && !chip_select_n && sec_ok);
  ctrl_write_c: cover property (!ctrl_addr_strobe_n && proc_addr_strobe_n && wr);
  apb_err_c: cover property (pready && pslverr);
endmodule
bind sync_burst_sram_ctrl sram_ctrl_checker u_sram_ctrl_checker (.*);
`default_nettype wire

// ===== sync_burst_sram_ctrl_tb.sv
// Self-checking bench of the burst SRAM core
`timescale 1ns/1ps
`default_nettype none
`include "sram_ctrl_consts.vh"
// ==========================
// Bench top
module sync_burst_sram_ctrl_tb;
  reg clock, rst, burst_order_mode, psel, penable, pwrite;
  reg [7:0] paddr;
  reg [31:0] pwdata, rd;
  reg e;
  reg flip; // Sets the order pin against the expected order
  reg [18:0] q; // Previous cycle's result
  wire [31:0] prdata;
  wire pready, pslverr, chip_select_n, second_select_n, third_select;
  wire proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, global_wr_n;
  wire byte_wr_gate_n, upper_byte_wr_n, lower_byte_wr_n, output_enable_n;
  wire data_io_bus_oe_n, lower_parity_bit_out, upper_parity_bit_out;
  wire lower_parity_bit_oe_n, upper_parity_bit_oe_n;
  wire [15:0] ext_addr, data_io_bus_out;
  wire [17:0] bus;
  wire [15:0] data_io_bus_in = bus[15:0];
  wire lower_parity_bit_in = bus[16];
  wire upper_parity_bit_in = bus[17];
  integer err_total, tests_run, cycles;
  sync_burst_sram_ctrl u_sync_burst_sram_ctrl (.*);
  sram_master_model u_sram_master_model (.*);
  initial begin
    clock = 0;
    forever #12.5 clock = ~clock;
  end
  // Hang guard
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      err_total = err_total + 1;
      test_done;
    end
  end
  task test_done;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk_w(input [18:0] g, input [18:0] x);
    begin
      tests_run = tests_run + 1;
      if (g !== x) begin
        err_total = err_total + 1;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  task chk_r(input [31:0] g, input [31:0] x);
    begin
      tests_run = tests_run + 1;
      if (g !== x) begin
        err_total = err_total + 1;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  task op(input [2:0] k, input [15:0] a, input [3:0] wc, input [17:0] d);
    u_sram_master_model.op(k, a, wc, d, q);
  endtask
  // One APB transfer; hang is cut by the guard
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clock);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rd = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  function [17:0] pat(input [15:0] a);
    pat = {a[1:0], a};
  endfunction
  task t_fill;
    integer i;
    for (i = 0; i < 4; i = i + 1)
      op(3, 16'h1230 + i[15:0], 4'h7, pat(16'h1230 + i[15:0]));
  endtask
  // Burst of four, then two wait cycles, the first one checked
  task t_burst(input m, input [1:0] s);
    integer n;
    reg [1:0] x;
    begin
      @(posedge clock);
      burst_order_mode <= m ^ flip;
      op(2, {14'h048C, s}, 4'hF, 18'h0);
      for (n = 1; n < 6; n = n + 1) begin
        op(n < 4 ? 3'd1 : 3'd0, 16'h0, 4'hF, 18'h0);
        x = n > 4 ? 2'd3 : 2'(n - 1);
        x = m ? s ^ x : s + x;
        chk_w(q, {1'b0, pat({14'h048C, x})});
      end
    end
  endtask
  // Six write-control mixes, then writes tied to the processor strobe
  task t_lanes;
    reg [23:0] tab;
    reg [17:0] x, d;
    reg [3:0] wc;
    reg lo, hi;
    integer i;
    begin
      tab = 24'h7A_98BC;
      x = pat(16'h1230);
      for (i = 0; i < 6; i = i + 1) begin
        wc = tab[23 - 4 * i -: 4];
        d = ~x;
        op(3, 16'h1230, wc, d);
        op(3, 16'h1230, 4'hF, 18'h0);
        op(0, 16'h0, 4'hF, 18'h0);
        lo = !wc[3] || (!wc[2] && !wc[0]);
        hi = !wc[3] || (!wc[2] && !wc[1]);
        x = {hi ? d[17] : x[17], lo ? d[16] : x[16], hi ? d[15:8] : x[15:8], lo ? d[7:0] : x[7:0]};
        chk_w(q, {1'b0, x});
      end
      op(2, 16'h1230, 4'h7, ~x);
      op(0, 16'h0, 4'hF, 18'h0);
      op(0, 16'h0, 4'hF, 18'h0);
      chk_w(q, {1'b0, x});
      op(2, 16'h1230, 4'hF, 18'h0);
      op(0, 16'h0, 4'h7, 18'h2_5A5A);
      op(3, 16'h1230, 4'hF, 18'h0);
      op(0, 16'h0, 4'hF, 18'h0);
      chk_w(q, {1'b0, 18'h2_5A5A});
    end
  endtask
  // Deselect forms, then a strobe under primary select high
  task t_desel;
    integer k;
    begin
      for (k = 5; k < 8; k = k + 1) begin
        op(2, 16'h1231, 4'hF, 18'h0);
        op(k[2:0], 16'h1231, 4'hF, 18'h0);
        op(0, 16'h0, 4'hF, 18'h0);
        chk_w({q[18], 18'h0}, {1'b1, 18'h0});
      end
      op(2, 16'h1230, 4'hF, 18'h0);
      op(4, 16'h0, 4'hF, 18'h0);
      op(5, 16'h0, 4'hF, 18'h0);
      chk_w(q, {1'b0, pat(16'h1231)});
    end
  endtask
  // Registers, unmapped place, trace buffer overflow and drain
  task t_apb;
    integer i;
    begin
      apb(0, `REG_CTRL, 0);
      chk_r(rd, `CTRL_RESET);
      apb(0, 8'h0C, 0);
      chk_r({31'h0, e}, 1);
      apb(0, `REG_STATUS, 0);
      chk_r(rd & 32'h0004_0000, 32'h0004_0000);
      for (i = 0; i < 5; i = i + 1) begin
        apb(0, `REG_TRACE, 0);
        chk_r(rd, i < 4 ? 32'h8002_1230 + i : 0);
      end
      apb(1, `REG_STATUS, 32'h0004_0000);
      apb(0, `REG_STATUS, 0);
      chk_r(rd & 32'h000C_0000, 0);
    end
  endtask
  // Software order override against the pin, then status of the held burst
  task t_order;
    begin
      // Trace off first, so the log stays empty from here on
      apb(1, `REG_CTRL, 32'h0000_0006);
      apb(0, `REG_CTRL, 0);
      chk_r(rd, 32'h0000_0006);
      // Restore the word that the write-after-read case changed
      op(3, 16'h1230, 4'h7, pat(16'h1230));
      flip = 1;
      t_burst(1, 2'd1);
      // Held burst on its fourth word: open, driving, nothing logged
      apb(0, `REG_STATUS, 0);
      chk_r(rd, 32'h0003_1232);
    end
  endtask
  initial begin
    rst = 1;
    {burst_order_mode, flip, psel, penable, pwrite, paddr, pwdata} = 0;
    {err_total, tests_run, cycles} = 0;
    repeat (3) @(posedge clock);
    rst <= 0;
    @(negedge clock);
    chk_r({29'h0, data_io_bus_oe_n, lower_parity_bit_oe_n, upper_parity_bit_oe_n}, 7);
    t_fill;
    t_burst(0, 2'd1);
    t_burst(0, 2'd3);
    t_burst(1, 2'd1);
    t_burst(1, 2'd2);
    t_lanes;
    t_desel;
    t_apb;
    t_order;
    test_done;
  end
endmodule
`default_nettype wire

// ===== trace_fifo.v
// Small synchronous FIFO in flip-flops with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module trace_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 4,
  parameter PTR_W = 2
) (
  input wire clock,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  // ==============================================
  // Storage and pointers
  reg [WIDTH-1:0] slot [0:DEPTH-1]; // Entries, indexed by pointer
  reg [PTR_W-1:0] wr_ptr; // Next slot to fill
  reg [PTR_W-1:0] rd_ptr; // Oldest slot
  reg [PTR_W:0] count; // One bit wider so full is distinct from empty
  wire push;
  wire pop;

  assign in_ready = (count != DEPTH[PTR_W:0]);
  assign out_valid = (count != {(PTR_W+1){1'b0}});
  assign out_data = slot[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer wrap kept explicit so DEPTH need not be a power of two
  function [PTR_W-1:0] bump;
    input [PTR_W-1:0] p;
    begin
      if (p == DEPTH[PTR_W-1:0] - 1'b1) begin
        bump = {PTR_W{1'b0}};
      end else begin
        bump = p + 1'b1;
      end
    end
  endfunction

  // ==============================================
  // Pointer and fill level
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr <= {PTR_W{1'b0}};
      rd_ptr <= {PTR_W{1'b0}};
      count <= {(PTR_W+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      // Simultaneous push and pop leaves the level alone
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  // Data slots carry no reset; valid gates them
  always @(posedge clock) begin
    if (push) begin
      slot[wr_ptr] <= in_data;
    end
  end

endmodule

`default_nettype wire
